//--- common/wtu_pkg.sv
// package: constants and types for the watchdog timeout unit
`default_nettype none
package wtu_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OPTION = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  // option register fields
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam int PSA_BIT = 3;
  localparam int PS_LSB = 0;
  localparam int PS_W = 3;
  // status register fields
  localparam int STAT_TO_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  // command register fields (write one to execute)
  localparam int CMD_CLRWDG_BIT = 0;
  localparam int CMD_SLEEP_BIT = 1;
  // base time-out
  localparam int WDG_PERIOD_US = 18000;
  localparam int WDG_OSC_KHZ = 128;
  localparam int WDG_BASE_TICKS = (WDG_PERIOD_US * WDG_OSC_KHZ) / 1000;
  localparam int BASE_W = 12;
  localparam int POST_W = 8;
  localparam logic [BASE_W-1:0] BASE_LAST = BASE_W'(WDG_BASE_TICKS - 1);
  typedef struct packed {
    logic reset_req;
    logic wake;
  } wtu_evt_t;
endpackage : wtu_pkg
`default_nettype wire

//--- design/wtu_top.sv
// design: watchdog timeout unit with apb register access
// Function
// R1 - counts on its own oscillator, ignoring sleep
// R2 - time-out while running resets the device
// R3 - time-out in sleep wakes the device
// R4 - configuration setting disables watchdog permanently
// R5 - base time-out about 18 ms of oscillator
// R6 - option register assigns postscaler up to 1:128
// R7 - clear and sleep commands clear counters
// R8 - every time-out clears the time-out flag
// R9 - three-bit power-of-two ratio, shared with timer
`default_nettype none
module wtu_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // watchdog oscillator and configuration pins
  input wire logic wdg_osc_in,
  input wire logic cfg_wdg_enable,
  // timer prescaler path
  input wire logic tmr_src_tick,
  output logic tmr_prescale_tick,
  // device events and state
  output wtu_pkg::wtu_evt_t evt,
  output logic sleeping
);
  logic osc_s1_r, osc_s2_r, osc_s3_r;
  logic en_s1_r, en_s2_r;
  logic [wtu_pkg::BASE_W-1:0] base_r, base_nxt;
  logic [wtu_pkg::POST_W-1:0] post_r, post_nxt;
  logic [7:0] opt_r, opt_nxt;
  logic to_n_r, to_n_nxt;
  logic sleep_r, sleep_nxt;
  logic rst_r, rst_nxt, wake_r, wake_nxt, ptick_r, ptick_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic tick, wr, ovf, timeout, clr, do_sleep, psa, mapped;
  logic [wtu_pkg::PS_W-1:0] ps;
  logic [8:0] wdg_lim, tmr_lim;

  // oscillator edge becomes a one-cycle tick; core sleep does not gate it
  assign tick = osc_s2_r & ~osc_s3_r; // R1
  assign wr = psel & penable & pwrite;
  assign clr = wr && paddr == wtu_pkg::OFF_CMD && pwdata[wtu_pkg::CMD_CLRWDG_BIT];
  assign do_sleep = wr && paddr == wtu_pkg::OFF_CMD && pwdata[wtu_pkg::CMD_SLEEP_BIT];
  assign psa = opt_r[wtu_pkg::PSA_BIT];
  assign ps = opt_r[wtu_pkg::PS_LSB +: wtu_pkg::PS_W];
  assign wdg_lim = (9'h001 << ps) - 9'h001; // R9
  assign tmr_lim = (9'h002 << ps) - 9'h001; // R9
  assign ovf = en_s2_r && tick && base_r == wtu_pkg::BASE_LAST; // R5
  // a count left above a lowered ratio expires at the next base overflow
  assign timeout = ovf && (!psa || post_r >= wdg_lim[7:0]); // R6
  assign mapped = paddr == wtu_pkg::OFF_OPTION || paddr == wtu_pkg::OFF_STATUS || paddr == wtu_pkg::OFF_CMD;

  always_comb begin
    base_nxt = base_r;
    post_nxt = post_r;
    opt_nxt = opt_r;
    to_n_nxt = to_n_r;
    sleep_nxt = sleep_r;
    rst_nxt = 1'b0;
    wake_nxt = 1'b0;
    ptick_nxt = 1'b0;
    prdata_nxt = prdata_r;
    if (wr && paddr == wtu_pkg::OFF_OPTION) begin
      opt_nxt = pwdata[7:0]; // R6
    end
    if (!en_s2_r) begin
      base_nxt = '0; // R4
    end else if (tick) begin
      base_nxt = ovf ? '0 : base_r + 1'b1; // R5
    end
    if (psa) begin
      if (ovf) begin
        post_nxt = timeout ? '0 : post_r + 1'b1; // R6
      end
    end else if (tmr_src_tick) begin
      ptick_nxt = post_r >= tmr_lim[7:0]; // R9
      post_nxt = ptick_nxt ? '0 : post_r + 1'b1; // R9
    end
    if (clr || do_sleep) begin
      to_n_nxt = 1'b1;
      base_nxt = '0; // R7
      if (psa) begin
        post_nxt = '0; // R7
      end
    end
    if (do_sleep) begin
      sleep_nxt = 1'b1;
    end
    // time-out beats a clear or sleep arriving in the same cycle
    if (timeout) begin
      to_n_nxt = 1'b0; // R8
      base_nxt = '0;
      if (sleep_r) begin
        wake_nxt = 1'b1; // R3
        sleep_nxt = 1'b0; // R3
      end else begin
        rst_nxt = 1'b1; // R2
      end
    end
    if (psel && !penable) begin
      if (paddr == wtu_pkg::OFF_OPTION) begin
        prdata_nxt = {24'h000000, opt_r};
      end else if (paddr == wtu_pkg::OFF_STATUS) begin
        prdata_nxt = '0;
        prdata_nxt[wtu_pkg::STAT_TO_BIT] = to_n_r;
        prdata_nxt[wtu_pkg::STAT_SLEEP_BIT] = sleep_r;
      end else begin
        prdata_nxt = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      base_r <= '0;
      post_r <= '0;
      opt_r <= wtu_pkg::OPTION_RST;
      to_n_r <= 1'b1;
      sleep_r <= 1'b0;
      rst_r <= 1'b0;
      wake_r <= 1'b0;
      ptick_r <= 1'b0;
      prdata_r <= '0;
    end else begin
      osc_s1_r <= wdg_osc_in;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
      en_s1_r <= cfg_wdg_enable;
      en_s2_r <= en_s1_r;
      base_r <= base_nxt;
      post_r <= post_nxt;
      opt_r <= opt_nxt;
      to_n_r <= to_n_nxt;
      sleep_r <= sleep_nxt;
      rst_r <= rst_nxt;
      wake_r <= wake_nxt;
      ptick_r <= ptick_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign evt = wtu_pkg::wtu_evt_t'{reset_req: rst_r, wake: wake_r};
  assign sleeping = sleep_r;
  assign tmr_prescale_tick = ptick_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wdg_expire;
    timeout ##1 !to_n_r;
  endsequence
  sequence s_reset_pulse;
    evt.reset_req && !evt.wake ##1 !evt.reset_req;
  endsequence
  property p_reset_on_expire;
    timeout && !sleep_r |=> s_reset_pulse;
  endproperty
  a_reset_on_expire: assert property (p_reset_on_expire) else $error("no reset pulse on time-out"); // R2
  property p_wake_on_expire;
    timeout && sleep_r |=> evt.wake && !evt.reset_req && !sleeping;
  endproperty
  a_wake_on_expire: assert property (p_wake_on_expire) else $error("no wake on time-out in sleep"); // R3
  property p_disabled_quiet;
    !en_s2_r |-> !timeout ##1 !evt.reset_req && !evt.wake;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("time-out while disabled"); // R4
  property p_base_wrap;
    ovf |=> base_r == '0;
  endproperty
  a_base_wrap: assert property (p_base_wrap) else $error("base counter did not wrap"); // R5
  property p_no_post_direct;
    en_s2_r && tick && !psa && base_r == wtu_pkg::BASE_LAST |-> timeout;
  endproperty
  a_no_post_direct: assert property (p_no_post_direct) else $error("missed base time-out"); // R5
  property p_post_ratio;
    ovf && psa && post_r < wdg_lim[7:0] && !clr && !do_sleep |-> !timeout ##1 post_r == $past(post_r) + 8'h01;
  endproperty
  a_post_ratio: assert property (p_post_ratio) else $error("postscaler ratio wrong"); // R6
  property p_clear;
    (clr || do_sleep) && !timeout |=> base_r == '0 && to_n_r;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not reset counter"); // R7
  property p_flag;
    timeout |-> s_wdg_expire;
  endproperty
  a_flag: assert property (p_flag) else $error("time-out flag not cleared"); // R8
  property p_opt_write;
    wr && paddr == wtu_pkg::OFF_OPTION |=> opt_r == $past(pwdata[7:0]);
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option write lost"); // R9
  property p_post_clear;
    (clr || do_sleep) && psa |=> post_r == '0;
  endproperty
  a_post_clear: assert property (p_post_clear) else $error("postscaler not cleared"); // R7
  property p_sleep_enter;
    do_sleep && !timeout |=> sleeping && to_n_r;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep command not taken"); // R7
  property p_tmr_tick;
    !psa && tmr_src_tick && post_r >= tmr_lim[7:0] |=> tmr_prescale_tick && post_r == '0;
  endproperty
  a_tmr_tick: assert property (p_tmr_tick) else $error("timer prescaler tick missing"); // R9
  property p_tmr_quiet;
    psa || !tmr_src_tick || post_r < tmr_lim[7:0] |=> !tmr_prescale_tick;
  endproperty
  a_tmr_quiet: assert property (p_tmr_quiet) else $error("stray timer prescaler tick"); // R9
endmodule : wtu_top
`default_nettype wire

//--- dv/testbench.sv
// testbench: self-checking bench for the watchdog timeout unit
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, osc = 0, cfg_en = 0, src = 0, ptick, sleeping;
  logic [3:0] up;
  wtu_pkg::wtu_evt_t evt;
  int n_mismatch = 0, checks = 0, cyc = 0, ph = 0, ticks = 0, t0 = 0, n_tmr = 0, n_evt = 0, b;
  wtu_top u_wtu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdg_osc_in(osc), .cfg_wdg_enable(cfg_en), .tmr_src_tick(src), .tmr_prescale_tick(ptick),
    .evt(evt), .sleeping(sleeping));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // watchdog oscillator at a fifth of pclk; rising edges counted
  always @(posedge pclk) begin
    ph <= (ph == 4) ? 0 : ph + 1;
    osc <= (ph < 2);
    if (ph == 0) ticks <= ticks + 1;
    if (ptick === 1'b1) n_tmr <= n_tmr + 1;
    if (evt.reset_req === 1'b1 || evt.wake === 1'b1) n_evt <= n_evt + 1;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      end_sim();
    end
  end
  function automatic int wdg_ticks(input int r);
    return wtu_pkg::WDG_BASE_TICKS << r;
  endfunction : wdg_ticks
  function automatic int tmr_div(input int r);
    return 2 << r;
  endfunction : tmr_div
  task end_sim;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_evt(input int exp);
    int n;
    n = 0;
    while (evt.reset_req !== 1'b1 && evt.wake !== 1'b1 && n < 40000) begin
      @(posedge pclk);
      n++;
    end
    `CHK((ticks - t0 >= exp - 2) && (ticks - t0 <= exp + 2), 1'b1)
  endtask : wait_evt
  initial begin
    up = 4'($urandom(47094));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, wtu_pkg::OFF_OPTION, 0);
    `CHK({err, rd}, {1'b0, 32'h000000FF})
    apb(0, wtu_pkg::OFF_STATUS, 0);
    `CHK(rd, 32'h00000001)
    apb(0, 8'h0C, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    for (int r = 0; r < 8; r++) begin
      up = 4'($urandom);
      apb(1, wtu_pkg::OFF_OPTION, {24'h0, up, 1'b0, 3'(r)});
      apb(0, wtu_pkg::OFF_OPTION, 0);
      `CHK(rd, {24'h0, up, 1'b0, 3'(r)})
      b = n_tmr;
      repeat (2 * tmr_div(r)) begin
        @(posedge pclk);
        src <= 1'b1;
        @(posedge pclk);
        src <= 1'b0;
      end
      repeat (3) @(posedge pclk);
      `CHK(n_tmr - b, 2)
    end
    b = n_evt;
    repeat (12500) @(posedge pclk);
    `CHK(n_evt - b, 0)
    cfg_en <= 1'b1;
    apb(1, wtu_pkg::OFF_OPTION, {24'h0, up, 4'h8});
    apb(1, wtu_pkg::OFF_CMD, 32'h1);
    repeat (7500) @(posedge pclk);
    apb(1, wtu_pkg::OFF_CMD, 32'h1);
    t0 = ticks;
    wait_evt(wdg_ticks(0));
    `CHK({evt.reset_req, evt.wake}, 2'b10)
    apb(0, wtu_pkg::OFF_STATUS, 0);
    `CHK(rd[1:0], 2'b00)
    apb(1, wtu_pkg::OFF_CMD, 32'h1);
    apb(1, wtu_pkg::OFF_OPTION, {24'h0, up, 4'h9});
    apb(1, wtu_pkg::OFF_CMD, 32'h2);
    t0 = ticks;
    apb(0, wtu_pkg::OFF_STATUS, 0);
    `CHK(rd[1:0], 2'b11)
    wait_evt(wdg_ticks(1));
    `CHK({evt.reset_req, evt.wake, sleeping}, 3'b010)
    apb(0, wtu_pkg::OFF_STATUS, 0);
    `CHK(rd[1:0], 2'b00)
    end_sim();
  end
endmodule : testbench
`default_nettype wire
